// ===== src/radio_pin_map.svh
// Register offsets, field positions, codes and reset values for the pin mapping block
`ifndef RADIO_PIN_MAP_SVH
`define RADIO_PIN_MAP_SVH
// Byte offsets on the register bus
`define OFS_SEL_A 5'h00
`define OFS_SEL_B 5'h04
`define OFS_CTRL 5'h08
`define OFS_EV_STATUS 5'h0c
`define OFS_EV_MASK 5'h10
`define OFS_PIN_STATE 5'h14
// Control field positions
`define CTL_PKT_BIT 0
`define CTL_STATE_LSB 1
`define CTL_STATE_MSB 3
`define CTL_BSYNC_BIT 4
`define CTL_WIDTH 5
// Event bit positions
`define EV_RX_DONE 0
`define EV_TX_DONE 1
`define EV_FULL 2
`define EV_MATCH 3
`define EV_WIDTH 4
// Mapping codes
`define MAP_00 2'h0
`define MAP_01 2'h1
`define MAP_10 2'h2
`define MAP_11 2'h3
// Reset values
`define SEL_A_RST 8'h00
`define SEL_B_RST 4'h0
`define CTRL_RST 5'h00
`define MASK_RST 4'h0
// Fixed queue capacity in bytes, shown in the pin state register
`define QUEUE_BYTES 7'h40
`define QUEUE_LSB 8
`endif

// ===== src/radio_pkg.sv
// Types shared by the pin mapping block
package radio_pkg;
  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_STANDBY = 3'h1,
    ST_FS_TX = 3'h2,
    ST_TX = 3'h3,
    ST_FS_RX = 3'h4,
    ST_RX = 3'h5
  } chip_state_t;
  typedef struct packed {
    logic rx_message_complete;
    logic tx_frame_done;
    logic check_sum_pass;
    logic queue_threshold_hit;
    logic queue_drained;
    logic queue_saturated;
    logic pattern_match;
    logic transmit_armed;
    logic receive_armed;
    logic state_settled;
    logic ref_clock_output;
    logic synth_locked;
    logic thermal_shift;
    logic supply_low;
    logic lead_in_seen;
    logic rssi_hit;
    logic timeout_hit;
  } radio_status_t;
endpackage

// ===== src/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sync2

// ===== src/bit_clock_gen.sv
// Divider that makes the serial bit clock and marks its edges
`timescale 1ns/1ps
module bit_clock_gen #(
  parameter int HALF_CYC = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic run,
  // Bit clock and edge pulses
  output logic bit_clk,
  output logic rise,
  output logic fall
);
  localparam int CW = $clog2(HALF_CYC + 1);
  logic [CW-1:0] cnt_r;
  logic flip;
  assign flip = run && (cnt_r == CW'(HALF_CYC - 1));
  // Edge pulses line up with the edge where bit_clk changes
  assign rise = flip && !bit_clk;
  assign fall = flip && bit_clk;
  // Stopped clock parks low so the first edge out is a rising one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      bit_clk <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      bit_clk <= 1'b0;
    end else if (flip) begin
      cnt_r <= '0;
      bit_clk <= !bit_clk;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end
endmodule // bit_clock_gen

// ===== src/pin_mux.sv
// Source selection for six general pins and the continuous serial data path
// Operation
// - Six pins pick a source by a two-bit code from two select registers, per data mode; pin two ignores its code in continuous mode.
// - In continuous rx/tx pin two carries data; code 00 puts bit clock on pin one, match/armed on pin zero.
// - In packet mode pin zero shows message complete or frame done (00) or checksum pass (01); pin one shows queue flags.
// - Continuous mode exchanges NRZ data on the two-way data pin with queue and packet handler off.
// - Continuous transmit drives a bit clock and captures the host bit on each rising edge.
// - Continuous receive without bit sync puts raw demodulator data on the pin and no clock.
// - Continuous receive with bit sync gives clean data and clock, data updated on the falling edge.
// - Packet mode puts no modem data on pins; data goes through the queue over the serial port.
// - Packet mode runs the packet handler for preamble, sync, check sum, coding and address filter.
// - Queue access by the host is allowed in sleep and standby too.
// - Packet mode forces bit sync on whatever the host setting.
// - Frame done asserts when the last bit of the frame has left the shift register.
// - The queue holds a fixed 64 bytes.
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "radio_pin_map.svh"
module pin_mux #(
  parameter int BIT_HALF_CYC = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // Internal radio status, same clock
  input wire radio_pkg::radio_status_t radio_status,
  input wire logic demod_raw,
  // Towards modulator and packet logic
  output logic tx_bit_to_mod,
  output logic packet_handler_en,
  output logic queue_host_access_en,
  output logic bit_sync_active,
  // Pins
  output logic gp_pin_zero,
  output logic gp_pin_one_bit_clock,
  input wire logic gp_pin_two_serial_line_in,
  output logic gp_pin_two_serial_line_out,
  output logic gp_pin_two_serial_line_oe,
  output logic gp_pin_three,
  output logic gp_pin_four,
  output logic gp_pin_five
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] pin_source_select_a_r;
  logic [3:0] pin_source_select_b_r;
  logic [`CTL_WIDTH-1:0] ctrl_r;
  logic [`EV_WIDTH-1:0] ev_status_r;
  logic [`EV_WIDTH-1:0] ev_mask_r;
  logic [`EV_WIDTH-1:0] ev_hit;
  logic [`EV_WIDTH-1:0] ev_prev_r;
  logic ack_r;
  logic take;
  logic [31:0] rd_nxt;
  logic [31:0] readdata_r;
  radio_pkg::chip_state_t st;
  logic pkt_mode;
  logic cont_rx;
  logic cont_tx;
  logic bsync_eff;
  logic bc_run;
  logic bc_clk;
  logic bc_rise;
  logic bc_fall;
  logic data_in_sync;
  logic rx_sample_r;
  logic rx_data_r;
  logic [1:0] code [6];
  logic [5:0] pins_nxt;
  logic [5:0] pins_r;
  logic oe_nxt;
  logic oe_r;
  logic sleep_st;
  logic rx_st;
  logic tx_st;
  logic fs_st;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign st = radio_pkg::chip_state_t'(ctrl_r[`CTL_STATE_MSB:`CTL_STATE_LSB]);
  assign pkt_mode = ctrl_r[`CTL_PKT_BIT];
  assign sleep_st = (st == radio_pkg::ST_SLEEP);
  assign rx_st = (st == radio_pkg::ST_RX);
  assign tx_st = (st == radio_pkg::ST_TX);
  assign fs_st = (st == radio_pkg::ST_FS_RX) || (st == radio_pkg::ST_FS_TX);
  assign cont_rx = !pkt_mode && rx_st;
  assign cont_tx = !pkt_mode && tx_st;
  assign bsync_eff = pkt_mode || ctrl_r[`CTL_BSYNC_BIT];
  assign bit_sync_active = bsync_eff;
  assign packet_handler_en = pkt_mode;
  // Queue is reachable in every chip state once packet mode is chosen
  assign queue_host_access_en = pkt_mode;
  // Clock runs for transmit, and for receive only when bit sync cleans data
  assign bc_run = cont_tx || (cont_rx && bsync_eff);

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs and bit clock
  sync2 #(.WIDTH(1)) u_data_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(gp_pin_two_serial_line_in),
    .q(data_in_sync)
  );
  bit_clock_gen #(.HALF_CYC(BIT_HALF_CYC)) u_bit_clk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(bc_run),
    .bit_clk(bc_clk),
    .rise(bc_rise),
    .fall(bc_fall)
  );

  // Host bit captured at the rising bit clock; sync delay assumes slow bit rates
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit_to_mod <= 1'b0;
    end else if (cont_tx && bc_rise) begin
      tx_bit_to_mod <= data_in_sync;
    end
  end

  // Demodulator sampled on rise, shown on fall so the host samples mid-bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_sample_r <= 1'b0;
      rx_data_r <= 1'b0;
    end else begin
      if (bc_rise) begin
        rx_sample_r <= demod_raw;
      end
      if (cont_rx && bc_fall) begin
        rx_data_r <= rx_sample_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection per pin
  assign code[0] = pin_source_select_a_r[1:0];
  assign code[1] = pin_source_select_a_r[3:2];
  assign code[2] = pin_source_select_a_r[5:4];
  assign code[3] = pin_source_select_a_r[7:6];
  assign code[4] = pin_source_select_b_r[1:0];
  assign code[5] = pin_source_select_b_r[3:2];

  // Every path starts low, so unmapped codes drive a quiet zero
  always_comb begin
    pins_nxt = 6'h00;
    oe_nxt = 1'b1;
    if (!pkt_mode) begin
      // Continuous mode
      case (code[0])
        `MAP_00: pins_nxt[0] = rx_st ? radio_status.pattern_match :
          (tx_st && radio_status.transmit_armed);
        `MAP_01: pins_nxt[0] = rx_st && (radio_status.rssi_hit || radio_status.lead_in_seen);
        `MAP_10: pins_nxt[0] = rx_st ? radio_status.receive_armed :
          (tx_st && radio_status.transmit_armed);
        default: pins_nxt[0] = 1'b0;
      endcase
      case (code[1])
        `MAP_00: pins_nxt[1] = bc_clk;
        `MAP_01: pins_nxt[1] = rx_st && (radio_status.rssi_hit || radio_status.lead_in_seen);
        default: pins_nxt[1] = 1'b0;
      endcase
      // Data for every code; host owns the line during transmit
      if (cont_tx) begin
        oe_nxt = 1'b0;
      end else if (cont_rx) begin
        pins_nxt[2] = bsync_eff ? rx_data_r : demod_raw;
      end
      case (code[3])
        `MAP_00: pins_nxt[3] = rx_st && radio_status.timeout_hit;
        `MAP_01: pins_nxt[3] = rx_st && (radio_status.rssi_hit || radio_status.lead_in_seen);
        `MAP_11: pins_nxt[3] = !sleep_st && (radio_status.thermal_shift || radio_status.supply_low);
        default: pins_nxt[3] = 1'b0;
      endcase
      case (code[4])
        `MAP_00: pins_nxt[4] = (fs_st || rx_st || tx_st) &&
          (radio_status.thermal_shift || radio_status.supply_low);
        `MAP_01: pins_nxt[4] = (fs_st || rx_st || tx_st) && radio_status.synth_locked;
        `MAP_10: pins_nxt[4] = (fs_st || rx_st) && radio_status.timeout_hit;
        default: pins_nxt[4] = !sleep_st && radio_status.state_settled;
      endcase
      case (code[5])
        `MAP_00: pins_nxt[5] = radio_status.ref_clock_output;
        `MAP_01: pins_nxt[5] = (fs_st || rx_st || tx_st) && radio_status.synth_locked;
        `MAP_10: pins_nxt[5] = rx_st && (radio_status.rssi_hit || radio_status.lead_in_seen);
        default: pins_nxt[5] = !sleep_st && radio_status.state_settled;
      endcase
    end else begin
      // Packet mode: flags only, modem data never reaches a pin
      case (code[0])
        `MAP_00: pins_nxt[0] = rx_st ? radio_status.rx_message_complete :
          (tx_st && radio_status.tx_frame_done);
        `MAP_01: pins_nxt[0] = rx_st && radio_status.check_sum_pass;
        `MAP_11: pins_nxt[0] = !sleep_st && (radio_status.thermal_shift || radio_status.supply_low);
        default: pins_nxt[0] = 1'b0;
      endcase
      case (code[1])
        `MAP_00: pins_nxt[1] = radio_status.queue_threshold_hit;
        `MAP_01: pins_nxt[1] = radio_status.queue_drained;
        `MAP_10: pins_nxt[1] = radio_status.queue_saturated;
        default: pins_nxt[1] = 1'b0;
      endcase
      case (code[2])
        `MAP_00: pins_nxt[2] = radio_status.queue_saturated;
        `MAP_01: pins_nxt[2] = rx_st && radio_status.receive_armed;
        `MAP_10: pins_nxt[2] = rx_st ? radio_status.timeout_hit : radio_status.queue_saturated;
        default: pins_nxt[2] = rx_st ? radio_status.pattern_match : radio_status.queue_saturated;
      endcase
      case (code[3])
        `MAP_01: pins_nxt[3] = tx_st && radio_status.transmit_armed;
        default: pins_nxt[3] = radio_status.queue_drained;
      endcase
      case (code[4])
        `MAP_00: pins_nxt[4] = !sleep_st && (radio_status.thermal_shift || radio_status.supply_low);
        `MAP_01: pins_nxt[4] = (fs_st || rx_st || tx_st) && radio_status.synth_locked;
        `MAP_10: pins_nxt[4] = rx_st && radio_status.timeout_hit;
        default: pins_nxt[4] = rx_st && (radio_status.rssi_hit || radio_status.lead_in_seen);
      endcase
      case (code[5])
        `MAP_00: pins_nxt[5] = radio_status.ref_clock_output;
        `MAP_01: pins_nxt[5] = (fs_st || rx_st || tx_st) && radio_status.synth_locked;
        `MAP_11: pins_nxt[5] = !sleep_st && radio_status.state_settled;
        default: pins_nxt[5] = 1'b0;
      endcase
    end
  end

  // Pins come from flops; one cycle of lag on every source
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_r <= 6'h00;
      oe_r <= 1'b1;
    end else begin
      pins_r <= pins_nxt;
      oe_r <= oe_nxt;
    end
  end
  assign gp_pin_zero = pins_r[0];
  assign gp_pin_one_bit_clock = pins_r[1];
  assign gp_pin_two_serial_line_out = pins_r[2];
  assign gp_pin_two_serial_line_oe = oe_r;
  assign gp_pin_three = pins_r[3];
  assign gp_pin_four = pins_r[4];
  assign gp_pin_five = pins_r[5];

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one wait cycle, then the answer
  assign take = (avs_read || avs_write) && ack_r;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = readdata_r;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (avs_address)
      `OFS_SEL_A: rd_nxt[7:0] = pin_source_select_a_r;
      `OFS_SEL_B: rd_nxt[3:0] = pin_source_select_b_r;
      `OFS_CTRL: rd_nxt[`CTL_WIDTH-1:0] = ctrl_r;
      `OFS_EV_STATUS: rd_nxt[`EV_WIDTH-1:0] = ev_status_r | ev_hit; // Wait-cycle event not lost
      `OFS_EV_MASK: rd_nxt[`EV_WIDTH-1:0] = ev_mask_r;
      `OFS_PIN_STATE: rd_nxt = {17'h00000, `QUEUE_BYTES, oe_r, bc_clk, pins_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Acknowledge and read data latched in the wait cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (avs_read && !ack_r) begin
        readdata_r <= rd_nxt;
      end
    end
  end

  // Software writable configuration
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_source_select_a_r <= `SEL_A_RST;
      pin_source_select_b_r <= `SEL_B_RST;
      ctrl_r <= `CTRL_RST;
      ev_mask_r <= `MASK_RST;
    end else if (take && avs_write && avs_byteenable[0]) begin
      case (avs_address)
        `OFS_SEL_A: pin_source_select_a_r <= avs_writedata[7:0];
        `OFS_SEL_B: pin_source_select_b_r <= avs_writedata[3:0];
        `OFS_CTRL: ctrl_r <= avs_writedata[`CTL_WIDTH-1:0];
        `OFS_EV_MASK: ev_mask_r <= avs_writedata[`EV_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events: rising edges of the main flags
  assign ev_hit = {radio_status.pattern_match, radio_status.queue_saturated,
                   radio_status.tx_frame_done, radio_status.rx_message_complete} & ~ev_prev_r;

  // Sticky status, cleared by a read; a new event in that cycle survives
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev_r <= '0;
      ev_status_r <= '0;
    end else begin
      ev_prev_r <= {radio_status.pattern_match, radio_status.queue_saturated,
                    radio_status.tx_frame_done, radio_status.rx_message_complete};
      if (take && avs_read && (avs_address == `OFS_EV_STATUS)) begin
        ev_status_r <= ev_hit;
      end else begin
        ev_status_r <= ev_status_r | ev_hit;
      end
    end
  end
  assign irq = |(ev_status_r & ev_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  tx_capture_a: assert property (cont_tx && bc_rise |=> tx_bit_to_mod == $past(data_in_sync))
    else $error("transmit bit not captured at bit clock rise");
  rx_fall_only_a: assert property ($changed(rx_data_r) |-> $past(bc_fall))
    else $error("receive data changed away from falling bit clock");
  raw_no_clock_a: assert property (cont_rx && !bsync_eff |-> !bc_run ##1 pins_r[2] == $past(demod_raw))
    else $error("raw receive path wrong or clock running");
  host_drives_a: assert property (cont_tx |=> !gp_pin_two_serial_line_oe)
    else $error("device drives data pin in continuous transmit");
  bsync_force_a: assert property (pkt_mode |-> bit_sync_active && packet_handler_en)
    else $error("packet mode without bit sync or packet handler");
  pkt_pin0_a: assert property (pkt_mode && rx_st && code[0] == `MAP_01 && $stable(ctrl_r)
    |=> gp_pin_zero == $past(radio_status.check_sum_pass))
    else $error("pin zero does not follow checksum pass");
  cont_clk_pin_a: assert property (!pkt_mode && code[1] == `MAP_00 |=> gp_pin_one_bit_clock == $past(bc_clk))
    else $error("pin one does not carry bit clock");
  unmapped_low_a: assert property (!pkt_mode && code[3] == `MAP_10 |=> !gp_pin_three)
    else $error("unmapped pin not low");
  queue_access_a: assert property (pkt_mode && sleep_st |-> queue_host_access_en)
    else $error("queue blocked in sleep");
  sticky_set_a: assert property (ev_hit[`EV_TX_DONE] |=> ev_status_r[`EV_TX_DONE])
    else $error("frame done event lost");
  bus_wait_a: assert property (avs_read && !ack_r |=> !avs_waitrequest || !avs_read)
    else $error("bus answer later than one wait cycle");

  tx_cov_c: cover property (cont_tx && bc_rise);
  rx_cov_c: cover property (cont_rx && bsync_eff && bc_fall);
  irq_cov_c: cover property (irq ##1 take && avs_read);
  pkt_cov_c: cover property (pkt_mode && gp_pin_zero);
endmodule // pin_mux

// ===== tb/host_mcu.sv
// Host side model: paces transmit bits from the bit clock, samples receive bits
`timescale 1ns/1ps
module host_mcu (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link pins
  input wire logic bit_clk_pin,
  input wire logic serial_wire,
  // Bench control
  input wire logic tx_en,
  input wire logic [7:0] tx_pattern,
  // Host drive and captured bit
  output logic host_drv,
  output logic rx_bit
);
  logic clk_prev_r;
  logic [2:0] idx_r;
  //////////////////////////////////////////////////////////////////////
  // Edge finder on the device bit clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= bit_clk_pin;
    end
  end
  // New bit only after a falling edge, far from the sampling rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      host_drv <= 1'b0;
      idx_r <= 3'h7;
    end else if (tx_en) begin
      if (clk_prev_r && !bit_clk_pin) begin
        host_drv <= tx_pattern[idx_r];
        idx_r <= idx_r - 3'h1;
      end
    end else begin
      host_drv <= ~host_drv; // Released: toggles so no stale level is read
    end
  end
  // Receive bit taken at each rising edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_bit <= 1'b0;
    end else if (!clk_prev_r && bit_clk_pin) begin
      rx_bit <= serial_wire;
    end
  end
endmodule // host_mcu

// ===== tb/pin_mux_tb.sv
// Self-checking bench for the pin mapping block
`timescale 1ns/1ps
`include "radio_pin_map.svh"
module pin_mux_tb;
  logic clk_sys;
  logic rst_n;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  radio_pkg::radio_status_t st;
  logic demod_raw;
  logic tx_bit;
  logic ph_en;
  logic q_en;
  logic bs_on;
  logic p0, p1, p2o, p2oe, p3, p4, p5;
  logic serial_wire;
  logic host_drv;
  logic rx_bit;
  logic tx_en;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  //////////////////////////////////////////////////////////////////////
  // Wider bit period gives the two-flop input path margin
  pin_mux #(.BIT_HALF_CYC(8)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .radio_status(st), .demod_raw(demod_raw), .tx_bit_to_mod(tx_bit),
    .packet_handler_en(ph_en), .queue_host_access_en(q_en), .bit_sync_active(bs_on),
    .gp_pin_zero(p0), .gp_pin_one_bit_clock(p1), .gp_pin_two_serial_line_in(serial_wire),
    .gp_pin_two_serial_line_out(p2o), .gp_pin_two_serial_line_oe(p2oe),
    .gp_pin_three(p3), .gp_pin_four(p4), .gp_pin_five(p5));
  host_mcu host_u (.clk_sys(clk_sys), .rst_n(rst_n), .bit_clk_pin(p1),
    .serial_wire(serial_wire), .tx_en(tx_en), .tx_pattern(8'hb4),
    .host_drv(host_drv), .rx_bit(rx_bit));
  // Wire level from whichever side drives
  assign serial_wire = p2oe ? p2o : host_drv;
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Hang guard, well above the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus cycles: hold until waitrequest is seen low, release after that edge
  task automatic bus_write(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= 1'b1;
    avs_address <= a;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs();
    logic [31:0] d;
    bus_read(`OFS_SEL_A, d);
    check("select a", d, 32'h0);
    bus_read(`OFS_CTRL, d);
    check("control", d, 32'h0);
    bus_read(`OFS_PIN_STATE, d);
    check("queue bytes", d[14:8], 32'h40);
    bus_read(5'h18, d);
    check("unmapped", d, 32'h0);
    bus_write(`OFS_SEL_B, 8'h0f, 4'h0);
    bus_read(`OFS_SEL_B, d);
    check("lane masked", d, 32'h0);
    $display("test reset_regs done");
  endtask
  task automatic t_packet();
    bus_write(`OFS_CTRL, 8'h01, 4'h1);
    settle();
    check("queue access sleep", q_en, 32'h1);
    check("sync forced", bs_on, 32'h1);
    check("handler on", ph_en, 32'h1);
    bus_write(`OFS_CTRL, 8'h0b, 4'h1);
    for (int k = 0; k < 3; k++) begin
      bus_write(`OFS_SEL_A, {4'h0, k[1:0], k[1:0]}, 4'h1);
      for (int p = 0; p < 2; p++) begin
        @(posedge clk_sys);
        st <= '0;
        st.rx_message_complete <= (p == 0);
        st.queue_threshold_hit <= (p == 0);
        st.queue_saturated <= (p == 0);
        st.check_sum_pass <= (p == 1);
        st.queue_drained <= (p == 1);
        demod_raw <= 1'b1;
        settle();
        check("pin zero", p0, (k == 0) ? p == 0 : (k == 1) ? p == 1 : 0);
        check("pin one", p1, (k == 1) ? p == 1 : p == 0);
        check("pin two", p2o, p == 0);
      end
    end
    bus_write(`OFS_SEL_A, 8'h00, 4'h1);
    bus_write(`OFS_CTRL, 8'h07, 4'h1);
    st <= '0;
    st.tx_frame_done <= 1'b1;
    settle();
    check("frame done", p0, 32'h1);
    $display("test packet done");
  endtask
  task automatic t_cont_rx_raw();
    logic [15:0] pat;
    pat = 16'h3a5c;
    @(posedge clk_sys);
    st <= '0;
    st.timeout_hit <= 1'b1;
    st.ref_clock_output <= 1'b1;
    bus_write(`OFS_CTRL, 8'h0a, 4'h1);
    settle();
    check("handler off", {ph_en, q_en}, 32'h0);
    check("pins three to five", {p3, p4, p5}, 32'h5);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      demod_raw <= pat[i];
      @(negedge clk_sys);
      if (i > 0) check("raw data", p2o, pat[i-1]);
      check("no clock", p1, 32'h0);
    end
    $display("test cont_rx_raw done");
  endtask
  task automatic t_cont_rx_sync();
    logic c_prev;
    logic d_prev;
    int rises;
    rises = 0;
    @(posedge clk_sys);
    c_prev = p1;
    d_prev = p2o;
    st.pattern_match <= 1'b1;
    bus_write(`OFS_CTRL, 8'h1a, 4'h1);
    for (int i = 0; i < 120; i++) begin
      @(posedge clk_sys);
      demod_raw <= (i < 60);
      @(negedge clk_sys);
      if (p1 && !c_prev) begin
        rises++;
        check("data held at rise", p2o, d_prev);
      end
      if (i == 58) check("clean bit one", rx_bit, 32'h1);
      c_prev = p1;
      d_prev = p2o;
    end
    check("clean bit zero", rx_bit, 32'h0);
    check("clock runs", rises > 4, 32'h1);
    check("match on pin", p0, 32'h1);
    $display("test cont_rx_sync done");
  endtask
  task automatic t_cont_tx();
    logic exp;
    @(posedge clk_sys);
    st <= '0;
    st.transmit_armed <= 1'b1;
    tx_en <= 1'b1;
    bus_write(`OFS_CTRL, 8'h06, 4'h1);
    settle();
    check("host drives", p2oe, 32'h0);
    check("armed on pin", p0, 32'h1);
    repeat (2) @(negedge p1);
    for (int b = 0; b < 8; b++) begin
      @(posedge p1);
      exp = host_drv;
      @(negedge p1);
      @(negedge clk_sys);
      check("captured bit", tx_bit, exp);
    end
    tx_en <= 1'b0;
    $display("test cont_tx done");
  endtask
  task automatic t_events();
    logic [31:0] d;
    @(posedge clk_sys);
    st <= '0;
    bus_write(`OFS_CTRL, 8'h00, 4'h1);
    bus_read(`OFS_EV_STATUS, d);
    bus_write(`OFS_EV_MASK, 8'h09, 4'h1);
    st.rx_message_complete <= 1'b1;
    settle();
    check("irq raised", irq, 32'h1);
    bus_write(`OFS_EV_MASK, 8'h08, 4'h1);
    settle();
    check("irq masked", irq, 32'h0);
    bus_write(`OFS_EV_STATUS, 8'hff, 4'h1);
    bus_read(`OFS_EV_STATUS, d);
    check("status set", d, 32'h1);
    bus_read(`OFS_EV_STATUS, d);
    check("status cleared", d, 32'h0);
    st.pattern_match <= 1'b1;
    settle();
    check("irq match", irq, 32'h1);
    bus_read(`OFS_EV_STATUS, d);
    settle();
    check("irq after clear", irq, 32'h0);
    $display("test events done");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    st = '0;
    demod_raw = 1'b0;
    tx_en = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset_regs();
    t_packet();
    t_cont_rx_raw();
    t_cont_rx_sync();
    t_cont_tx();
    t_events();
    final_report();
  end
endmodule // pin_mux_tb
